/* File: src/bflm_top.sv */
// Burner fault supervision, lockout and alert histories, counters and Wishbone registers.
// Notes on behaviour
// RULE_01 - self-check failure drops safety relay
// RULE_02 - unconfigured state blocks burner until confirmed
// RULE_03 - setting picks lockout persistence over power loss
// RULE_04 - button or remote reset clears lockout
// RULE_05 - bus reset write clears lockout
// RULE_06 - lockout log persists, alert log volatile
// RULE_07 - lockout stops burner, closes alarm, latches
// RULE_08 - lockouts appended to 15 entry history
// RULE_09 - alerts never stop burner nor latch
// RULE_10 - per-code bit gates alert onto alarm
// RULE_11 - alert history ordered, one entry per code
// RULE_12 - unrequested sensors raise no fault
// RULE_13 - requested sensor fault raises alert
// RULE_14 - redundant safety readings compared for mismatch
// RULE_15 - low and high distinct, not for digital
// RULE_16 - lockout record snapshots burner status values
// RULE_17 - cycle counters writable, controller ones not
// RULE_18 - flame loss acted on within four seconds
// RULE_19 - flame decided against configurable threshold
// RULE_20 - temperature parameter none blocks operation
// RULE_21 - safety parameter write forces lockout; code locks only from ready, when unconfigured only sets confirm pending
// RULE_22 - non-safety writes accepted at any time
// RULE_23 - cycle counters saturate at maximum
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
module bflm_top
  import bflm_pkg::*;
#(
  parameter int unsigned FLAME_LOSS_CYCLES = FLAME_LOSS_CYC,
  parameter int unsigned SENS_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from outside
  input wire logic reset_button_i,
  input wire logic remote_reset_i,
  input wire logic self_check_fail_i,
  input wire logic power_restored_i,
  input wire logic flame_raw_valid_i,
  input wire logic [15:0] flame_signal_i,
  input wire logic main_valve_i,
  input wire logic [7:0] burner_state_i,
  input wire logic [15:0] burner_timer_i,
  input wire logic [7:0] first_out_i,
  input wire logic [7:0] lockout_cause_i,
  input wire logic lockout_req_i,
  input wire logic [3:0] alert_code_i,
  input wire logic alert_req_i,
  // Sensor
  input wire logic [SENS_W-1:0] sens_a_i,
  input wire logic [SENS_W-1:0] sens_b_i,
  input wire logic sens_requested_i,
  input wire logic sens_redundant_i,
  input wire logic sens_digital_i,
  input wire logic sens_locks_i,
  // Outputs
  output logic safety_relay_o,
  output logic burner_enable_o,
  output logic alarm_o,
  output logic flame_on_o,
  output logic flame_fail_o,
  output logic lockout_o
);
  initial begin
    if (FLAME_LOSS_CYCLES < 1) $error("bflm_top: flame loss count below one");
    if (SENS_W < 2 || SENS_W > 16) $error("bflm_top: sensor width unsupported");
  end

  // Pin synchronisers.
  localparam int unsigned NSYNC = 4;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {power_restored_i, self_check_fail_i, remote_reset_i, reset_button_i};
      sync2_r <= sync1_r;
    end
  end
  logic btn_s, rem_s, chk_s, pwr_s;
  assign btn_s = sync2_r[0];
  assign rem_s = sync2_r[1];
  assign chk_s = sync2_r[2];
  assign pwr_s = sync2_r[3];

  logic btn_d_r, rem_d_r, pwr_d_r, mv_d_r;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      btn_d_r <= 1'b0;
      rem_d_r <= 1'b0;
      pwr_d_r <= 1'b0;
      mv_d_r <= 1'b0;
    end else begin
      btn_d_r <= btn_s;
      rem_d_r <= rem_s;
      pwr_d_r <= pwr_s;
      mv_d_r <= main_valve_i;
    end
  end

  // Wishbone decode.
  logic wb_req, wr_en, ack_r;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_en = wb_req && wb_we_i && wb_sel_i[0];
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Software registers.
  logic persist_r, confirm_pend_r;
  logic [15:0] alert_alarm_r, flame_thr_r;
  logic [31:0] nonsafe_r, safe_param_r;
  logic [11:0] temp_param_r;
  logic [3:0] cnt_sel_r, hist_sel_r;
  logic bus_reset, bus_confirm, safe_wr;
  assign bus_reset = wr_en && hit(wb_adr_i, ADR_CTRL) && wb_dat_i[CTRL_RESET_BIT]; // see RULE_05
  assign bus_confirm = wr_en && hit(wb_adr_i, ADR_CTRL) && wb_dat_i[CTRL_CONFIRM_BIT];
  assign safe_wr = wr_en && hit(wb_adr_i, ADR_SAFE_PARAM);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      persist_r <= 1'b0;
      alert_alarm_r <= ALERT_ALARM_RST;
      flame_thr_r <= FLAME_THR_RST;
      nonsafe_r <= '0;
      safe_param_r <= '0;
      temp_param_r <= TEMP_NONE;
      cnt_sel_r <= '0;
      hist_sel_r <= '0;
    end else if (wr_en) begin
      if (hit(wb_adr_i, ADR_CTRL)) begin
        persist_r <= wb_dat_i[CTRL_PERSIST_BIT]; // see RULE_03
      end else if (hit(wb_adr_i, ADR_ALERT_ALARM)) begin
        alert_alarm_r <= wb_dat_i[15:0];
      end else if (hit(wb_adr_i, ADR_FLAME_THR)) begin
        flame_thr_r <= wb_dat_i[15:0]; // see RULE_19
      end else if (hit(wb_adr_i, ADR_SAFE_PARAM)) begin
        safe_param_r <= wb_dat_i;
      end else if (hit(wb_adr_i, ADR_NONSAFE)) begin
        nonsafe_r <= wb_dat_i; // see RULE_22
      end else if (hit(wb_adr_i, ADR_TEMP_PARAM)) begin
        temp_param_r <= wb_dat_i[11:0];
      end else if (hit(wb_adr_i, ADR_CNT_SEL)) begin
        cnt_sel_r <= wb_dat_i[3:0];
      end else if (hit(wb_adr_i, ADR_HIST_SEL)) begin
        hist_sel_r <= wb_dat_i[3:0];
      end
    end
  end

  // Sensor faults.
  logic s_low, s_high, s_mis;
  bflm_sensor_check #(.W(SENS_W)) u_sens (
    .val_a_i(sens_a_i),
    .val_b_i(sens_b_i),
    .lo_lim_i(nonsafe_r[SENS_W-1:0]),
    .hi_lim_i(nonsafe_r[16+SENS_W-1:16]),
    .requested_i(sens_requested_i), // see RULE_12
    .redundant_i(sens_redundant_i), // see RULE_14
    .digital_i(sens_digital_i), // see RULE_15
    .low_o(s_low),
    .high_o(s_high),
    .mismatch_o(s_mis)
  );
  logic sens_fault, sens_fault_d_r, sens_alert, sens_lock;
  assign sens_fault = s_low || s_high || s_mis;
  assign sens_alert = sens_fault && !sens_fault_d_r && !sens_locks_i; // see RULE_13
  assign sens_lock = sens_fault && sens_locks_i;

  // Flame supervision: loss counted while burner runs.
  logic flame_on_r;
  logic [31:0] loss_cnt_r;
  logic flame_trip;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flame_on_r <= 1'b0;
    end else if (flame_raw_valid_i) begin
      flame_on_r <= flame_signal_i >= flame_thr_r; // see RULE_19
    end
  end
  assign flame_trip = (loss_cnt_r == FLAME_LOSS_CYCLES - 1) && !flame_on_r && main_valve_i;
  always_ff @(posedge mclk_i) begin
    if (reset_i || flame_on_r || !main_valve_i) begin
      loss_cnt_r <= '0;
    end else if (loss_cnt_r < FLAME_LOSS_CYCLES - 1) begin
      loss_cnt_r <= loss_cnt_r + 32'd1; // see RULE_18
    end
  end

  // Supervisory state.
  bflm_state_t state_r;
  logic clear_req, lock_evt;
  // Reset acts on release of the button or remote input.
  assign clear_req = (btn_d_r && !btn_s) || (rem_d_r && !rem_s) || bus_reset; // see RULE_04
  assign lock_evt = lockout_req_i || flame_trip || sens_lock || safe_wr;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_r <= BFLM_UNCONF;
      confirm_pend_r <= 1'b1;
    end else begin
      if (safe_wr) begin
        confirm_pend_r <= 1'b1; // see RULE_21
      end else if (bus_confirm) begin
        confirm_pend_r <= 1'b0; // see RULE_02
      end
      case (state_r)
        BFLM_UNCONF: begin
          if (!confirm_pend_r && temp_param_r != TEMP_NONE) begin
            state_r <= BFLM_READY; // see RULE_20
          end
        end
        BFLM_READY: begin
          if (lock_evt) begin
            state_r <= BFLM_LOCKED; // see RULE_07
          end else if (confirm_pend_r || temp_param_r == TEMP_NONE) begin
            state_r <= BFLM_UNCONF;
          end
        end
        default: begin
          // Power return clears the latch unless persistence is chosen.
          if ((clear_req || (pwr_s && !pwr_d_r && !persist_r)) && !lock_evt) begin
            state_r <= BFLM_UNCONF; // see RULE_03
          end
        end
      endcase
    end
  end

  assign safety_relay_o = !chk_s; // see RULE_01
  assign lockout_o = state_r == BFLM_LOCKED;
  assign burner_enable_o = (state_r == BFLM_READY) && !chk_s; // see RULE_09
  assign flame_on_o = flame_on_r;
  assign flame_fail_o = flame_trip;

  // Cycle and time counters.
  logic [19:0] cnt_r [NUM_CNT];
  logic [15:0] brt_pre_r;
  logic mv_rise;
  assign mv_rise = main_valve_i && !mv_d_r;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      brt_pre_r <= '0;
    end else begin
      brt_pre_r <= main_valve_i ? brt_pre_r + 16'd1 : brt_pre_r;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      logic inc;
      if (gi == 0 || gi == 7) begin : g_mv
        assign inc = mv_rise;
      end else if (gi == 6) begin : g_ctl
        assign inc = brt_pre_r == 16'hFFFF;
      end else if (gi == CNT_BRT) begin : g_brt
        assign inc = main_valve_i && brt_pre_r == 16'hFFFF;
      end else begin : g_ext
        assign inc = 1'b0;
      end
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          cnt_r[gi] <= '0;
        end else if (wr_en && hit(wb_adr_i, ADR_CNT_DATA) && cnt_sel_r == gi
                     && (gi <= CNT_WR_LAST || gi == CNT_BRT)) begin
          cnt_r[gi] <= (wb_dat_i[19:0] > CNT_MAX) ? CNT_MAX : wb_dat_i[19:0]; // see RULE_17
        end else if (inc && cnt_r[gi] != CNT_MAX) begin
          cnt_r[gi] <= cnt_r[gi] + 20'd1; // see RULE_23
        end
      end
    end
  endgenerate

  // Lockout history: newest at index 0; not cleared by reset_i loss of power.
  logic [31:0] lo_rec_r [HIST_DEPTH];
  logic [15:0] lo_tim_r [HIST_DEPTH];
  logic [19:0] lo_cyc_r [HIST_DEPTH];
  logic [19:0] lo_brt_r [HIST_DEPTH];
  logic [SENS_W-1:0] lo_sen_r [HIST_DEPTH];
  logic lock_entry;
  assign lock_entry = (state_r == BFLM_READY) && lock_evt;
  always_ff @(posedge mclk_i) begin
    if (lock_entry) begin
      lo_rec_r[0] <= {8'h00, lockout_cause_i, burner_state_i, first_out_i}; // see RULE_16
      lo_tim_r[0] <= burner_timer_i;
      lo_cyc_r[0] <= cnt_r[0];
      lo_brt_r[0] <= cnt_r[CNT_BRT];
      lo_sen_r[0] <= sens_a_i;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        lo_rec_r[i] <= lo_rec_r[i-1]; // see RULE_08
        lo_tim_r[i] <= lo_tim_r[i-1];
        lo_cyc_r[i] <= lo_cyc_r[i-1];
        lo_brt_r[i] <= lo_brt_r[i-1];
        lo_sen_r[i] <= lo_sen_r[i-1];
      end
    end
  end

  // Alert history: newest at index 0, a repeated code is pulled out of its old slot.
  logic [4:0] al_code_r [HIST_DEPTH];
  logic al_evt;
  logic [3:0] al_code;
  assign al_evt = alert_req_i || sens_alert;
  assign al_code = alert_req_i ? alert_code_i : 4'hF;
  logic [HIST_DEPTH-1:0] al_match;
  logic [HIST_DEPTH-1:0] al_shift;
  always_comb begin
    for (int i = 0; i < HIST_DEPTH; i++) begin
      al_match[i] = al_code_r[i][4] && al_code_r[i][3:0] == al_code;
    end
    al_shift[0] = 1'b1;
    for (int i = 1; i < HIST_DEPTH; i++) begin
      al_shift[i] = al_shift[i-1] && !al_match[i-1];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        al_code_r[i] <= '0; // see RULE_06
      end
    end else if (al_evt) begin
      al_code_r[0] <= {1'b1, al_code};
      for (int i = 1; i < HIST_DEPTH; i++) begin
        if (al_shift[i]) begin
          al_code_r[i] <= al_code_r[i-1]; // see RULE_11
        end
      end
    end
  end

  // Alarm contact.
  logic alert_pulse_r;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      alert_pulse_r <= 1'b0;
      sens_fault_d_r <= 1'b0;
    end else begin
      alert_pulse_r <= al_evt && alert_alarm_r[al_code]; // see RULE_10
      sens_fault_d_r <= sens_fault;
    end
  end
  assign alarm_o = lockout_o || alert_pulse_r;

  // Read path.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= wb_req;
      if (!wb_req) begin
        wb_dat_o <= '0;
      end else if (hit(wb_adr_i, ADR_CTRL)) begin
        wb_dat_o <= {29'd0, persist_r, 2'b00};
      end else if (hit(wb_adr_i, ADR_STATUS)) begin
        wb_dat_o <= {24'd0, s_mis, s_high, s_low, flame_on_r, !chk_s, confirm_pend_r, state_r};
      end else if (hit(wb_adr_i, ADR_ALERT_ALARM)) begin
        wb_dat_o <= {16'd0, alert_alarm_r};
      end else if (hit(wb_adr_i, ADR_FLAME_THR)) begin
        wb_dat_o <= {16'd0, flame_thr_r};
      end else if (hit(wb_adr_i, ADR_SAFE_PARAM)) begin
        wb_dat_o <= safe_param_r;
      end else if (hit(wb_adr_i, ADR_NONSAFE)) begin
        wb_dat_o <= nonsafe_r;
      end else if (hit(wb_adr_i, ADR_TEMP_PARAM)) begin
        wb_dat_o <= {20'd0, temp_param_r};
      end else if (hit(wb_adr_i, ADR_CNT_DATA) && cnt_sel_r < NUM_CNT) begin
        wb_dat_o <= {12'd0, cnt_r[cnt_sel_r]};
      end else if (wb_adr_i[7:6] == 2'b01 && hist_sel_r < HIST_DEPTH) begin
        case (wb_adr_i[4:2])
          3'd0: wb_dat_o <= lo_rec_r[hist_sel_r];
          3'd1: wb_dat_o <= {16'd0, lo_tim_r[hist_sel_r]};
          3'd2: wb_dat_o <= {12'd0, lo_cyc_r[hist_sel_r]};
          3'd3: wb_dat_o <= {12'd0, lo_brt_r[hist_sel_r]};
          3'd4: wb_dat_o <= 32'(lo_sen_r[hist_sel_r]); // see RULE_16
          default: wb_dat_o <= '0;
        endcase
      end else if (hit(wb_adr_i, ADR_AL_HIST) && hist_sel_r < HIST_DEPTH) begin
        wb_dat_o <= {27'd0, al_code_r[hist_sel_r]};
      end else begin
        wb_dat_o <= '0;
      end
    end
  end
  assign wb_ack_o = ack_r;

  a_lock_stops: assert property (@(posedge mclk_i) disable iff (reset_i)
    lockout_o |-> !burner_enable_o && alarm_o) else $error("lockout not safe"); // see RULE_07
  a_relay_drop: assert property (@(posedge mclk_i) disable iff (reset_i)
    chk_s |-> !safety_relay_o && !burner_enable_o) else $error("relay on"); // see RULE_01
  a_unconf_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    confirm_pend_r |-> ##1 !burner_enable_o) else $error("runs unconfirmed"); // see RULE_02
  a_safe_wr_lock: assert property (@(posedge mclk_i) disable iff (reset_i)
    safe_wr && state_r == BFLM_READY |=> lockout_o) else $error("no lock"); // see RULE_21
  a_none_blocks: assert property (@(posedge mclk_i) disable iff (reset_i)
    temp_param_r == TEMP_NONE && state_r != BFLM_READY |=> state_r != BFLM_READY)
    else $error("ran with none"); // see RULE_20
  a_lock_latched: assert property (@(posedge mclk_i) disable iff (reset_i)
    lockout_o && !clear_req && !(pwr_s && !pwr_d_r) |=> lockout_o)
    else $error("lock dropped"); // see RULE_07
  a_bus_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    lockout_o && bus_reset && !lock_evt |=> !lockout_o) else $error("no clear"); // see RULE_05
  a_cnt_sat: assert property (@(posedge mclk_i) disable iff (reset_i)
    cnt_r[0] == CNT_MAX && !(wr_en && hit(wb_adr_i, ADR_CNT_DATA)) |=> cnt_r[0] == CNT_MAX)
    else $error("wrapped"); // see RULE_23
  a_alert_no_lock: assert property (@(posedge mclk_i) disable iff (reset_i)
    alert_req_i && !lock_evt && state_r == BFLM_READY |=> !lockout_o)
    else $error("alert locked"); // see RULE_09
  a_flame_trip: assert property (@(posedge mclk_i) disable iff (reset_i)
    flame_trip && state_r == BFLM_READY |=> lockout_o) else $error("late trip"); // see RULE_18
endmodule

/* File: src/bflm_pkg.sv */
// Package with constants and types for the burner fault and lockout manager.
package bflm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FLAME_LOSS_RESPONSE_TIME_MS = 4000;
  // Longest time rounds down to whole cycles.
  localparam int unsigned FLAME_LOSS_CYC = (CLK_HZ / 1000) * FLAME_LOSS_RESPONSE_TIME_MS;
  localparam int unsigned HIST_DEPTH = 15;
  localparam logic [19:0] CNT_MAX = 20'hF_423F;
  localparam logic [11:0] TEMP_NONE = 12'hFFF;
  // Register byte addresses.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_ALERT_ALARM = 8'h08;
  localparam logic [7:0] ADR_FLAME_THR = 8'h0C;
  localparam logic [7:0] ADR_SAFE_PARAM = 8'h10;
  localparam logic [7:0] ADR_NONSAFE = 8'h14;
  localparam logic [7:0] ADR_TEMP_PARAM = 8'h18;
  localparam logic [7:0] ADR_CNT_SEL = 8'h1C;
  localparam logic [7:0] ADR_CNT_DATA = 8'h20;
  localparam logic [7:0] ADR_LO_HIST = 8'h40;
  localparam logic [7:0] ADR_AL_HIST = 8'h80;
  localparam logic [7:0] ADR_HIST_SEL = 8'h24;
  // Control register bit positions.
  localparam int unsigned CTRL_RESET_BIT = 0;
  localparam int unsigned CTRL_CONFIRM_BIT = 1;
  localparam int unsigned CTRL_PERSIST_BIT = 2;
  // Reset values.
  localparam logic [15:0] FLAME_THR_RST = 16'h0000;
  localparam logic [15:0] ALERT_ALARM_RST = 16'h0000;
  // Counter indices: 0 burner, 1 ch, 2 dhw, 3..5 pumps, 6 controller run, 7 control cycles,
  // 8 burner run time.
  localparam int unsigned NUM_CNT = 9;
  localparam int unsigned CNT_WR_LAST = 5;
  localparam int unsigned CNT_BRT = 8;
  typedef enum logic [1:0] {
    BFLM_UNCONF = 2'b00,
    BFLM_READY = 2'b01,
    BFLM_LOCKED = 2'b11
  } bflm_state_t;
endpackage

/* File: src/bflm_sensor_check.sv */
// Sensor fault classification and redundant comparison for one requested sensor.
module bflm_sensor_check #(
  parameter int unsigned W = 12
) (
  // Sensor readings and limits
  input wire logic [W-1:0] val_a_i,
  input wire logic [W-1:0] val_b_i,
  input wire logic [W-1:0] lo_lim_i,
  input wire logic [W-1:0] hi_lim_i,
  // Use of the sensor
  input wire logic requested_i,
  input wire logic redundant_i,
  input wire logic digital_i,
  // Fault classes
  output logic low_o,
  output logic high_o,
  output logic mismatch_o
);
  initial begin
    if (W < 2) $error("bflm_sensor_check: width too small");
  end
  always_comb begin
    low_o = requested_i && !digital_i && (val_a_i < lo_lim_i);
    high_o = requested_i && !digital_i && (val_a_i > hi_lim_i);
    mismatch_o = requested_i && redundant_i && (val_a_i != val_b_i);
  end
endmodule

/* File: tb/bflm_far_model.sv */
// Far-side model: a strobed flame detector and a momentary reset button.
module bflm_far_model (
  // Clock
  input wire logic mclk_i,
  // Scenario controls
  input wire logic flame_present_i,
  input wire logic press_i,
  // Lines into the block
  output logic flame_raw_valid_o,
  output logic [15:0] flame_signal_o,
  output logic reset_button_o
);
  logic [1:0] div_r = 2'd0;
  logic [3:0] hold_r = 4'd0;
  logic [15:0] sig_r = 16'h0000;
  logic vld_r = 1'b0;

  // Between strobes the sample line toggles so a stale value is never mistaken for data.
  always_ff @(posedge mclk_i) begin
    div_r <= div_r + 2'd1;
    vld_r <= (div_r == 2'd3);
    sig_r <= (div_r == 2'd3) ? (flame_present_i ? 16'h0200 : 16'h0010) : ~sig_r;
  end

  // A press is held for several cycles and then released, so the block sees a full stroke.
  always_ff @(posedge mclk_i) begin
    if (press_i) begin
      hold_r <= 4'd6;
    end else if (hold_r != 4'd0) begin
      hold_r <= hold_r - 4'd1;
    end
  end

  assign flame_raw_valid_o = vld_r;
  assign flame_signal_o = sig_r;
  assign reset_button_o = (hold_r != 4'd0);
endmodule

/* File: tb/bflm_top_tb.sv */
// Self-checking testbench for the burner fault and lockout manager.
module bflm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bflm_pkg::*;
  localparam int unsigned FLC = 20;
  logic mclk_i = 1'b0;
  logic reset_i, cyc, stb, we, ack, btn, rrst, scf, vld, valve, lreq, areq, req, red, dig;
  logic [7:0] adr, bst, fo, cause;
  logic [31:0] dat, rdat, q, base;
  logic [3:0] sel, acode;
  logic [15:0] fsig, tmr;
  logic [11:0] sa, sb;
  logic relay, en, alarm, fon, ffail, lck, flame_present, press, seen, pwr, slk;
  int n_errors = 0;
  int num_checks = 0;
  int tick = 0;

  always #50 mclk_i = ~mclk_i;

  bflm_top #(.FLAME_LOSS_CYCLES(FLC), .SENS_W(12)) bflm_top_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .reset_button_i(btn), .remote_reset_i(rrst), .self_check_fail_i(scf),
    .power_restored_i(pwr), .flame_raw_valid_i(vld), .flame_signal_i(fsig),
    .main_valve_i(valve), .burner_state_i(bst), .burner_timer_i(tmr), .first_out_i(fo),
    .lockout_cause_i(cause), .lockout_req_i(lreq), .alert_code_i(acode), .alert_req_i(areq),
    .sens_a_i(sa), .sens_b_i(sb), .sens_requested_i(req), .sens_redundant_i(red),
    .sens_digital_i(dig), .sens_locks_i(slk), .safety_relay_o(relay),
    .burner_enable_o(en), .alarm_o(alarm), .flame_on_o(fon), .flame_fail_o(ffail),
    .lockout_o(lck)
  );

  bflm_far_model bflm_far_model_i (
    .mclk_i(mclk_i), .flame_present_i(flame_present), .press_i(press),
    .flame_raw_valid_o(vld), .flame_signal_o(fsig), .reset_button_o(btn)
  );

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hung handshake must still reach the closing report.
  always @(posedge mclk_i) begin
    tick++;
    if (tick == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle: request held until ack is sampled high, then released for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge mclk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic rd_cnt(input logic [31:0] idx);
    wr(ADR_CNT_SEL, idx);
    rd(ADR_CNT_DATA);
  endtask

  task automatic state_is(input logic [1:0] s);
    rd(ADR_STATUS);
    chk("state", 32'(s), 32'(q[1:0]));
  endtask

  task automatic alert(input logic [3:0] c);
    acode <= c;
    areq <= 1'b1;
    @(posedge mclk_i);
    areq <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      seen = seen | alarm;
    end
  endtask

  task automatic lock_now;
    lreq <= 1'b1;
    @(posedge mclk_i);
    lreq <= 1'b0;
    cy(3);
  endtask

  task automatic sens(input logic [11:0] a, input logic [11:0] b, input logic [2:0] use_bits,
                      input logic [2:0] exp);
    sa <= a;
    sb <= b;
    {req, red, dig} <= use_bits;
    cy(4);
    rd(ADR_STATUS);
    chk("sensor faults", 32'(exp), 32'(q[7:5]));
  endtask

  task automatic t_defaults;
    state_is(2'b00);
    rd(ADR_TEMP_PARAM);
    chk("temp none", 32'(TEMP_NONE), q & 32'h0000_0FFF);
    wr(ADR_CTRL, 32'h0000_0002);
    cy(3);
    state_is(2'b00);
    wr(8'h30, 32'h1234_5678);
    rd(8'h30);
    chk("unmapped", 32'h0000_0000, q);
    chk("enable idle", 32'h0, 32'(en));
  endtask

  task automatic t_configure;
    wr(ADR_TEMP_PARAM, 32'h0000_0050);
    wr(ADR_FLAME_THR, 32'h0000_0100);
    wr(ADR_CTRL, 32'h0000_0002);
    cy(3);
    state_is(2'b01);
    chk("enable ready", 32'h1, 32'(en));
    flame_present <= 1'b1;
    cy(12);
    chk("flame on", 32'h1, 32'(fon));
    rd_cnt(32'h0000_0000);
    base = q;
    valve <= 1'b1;
    cy(3);
    rd_cnt(32'h0000_0000);
    chk("burner cycles", base + 32'h1, q);
  endtask

  task automatic t_lockout;
    bst <= 8'h05;
    fo <= 8'h22;
    cause <= 8'h11;
    tmr <= 16'h0ABC;
    sa <= 12'h123;
    lock_now();
    chk("lockout", 32'h6, 32'({lck, alarm, en}));
    wr(ADR_HIST_SEL, 32'h0000_0000);
    rd(ADR_LO_HIST);
    chk("record ids", 32'h0011_0522, q);
    rd(ADR_LO_HIST + 8'h04);
    chk("record timer", 32'h0000_0ABC, q);
    rd(ADR_LO_HIST + 8'h08);
    chk("record cycles", base + 32'h1, q);
    rd(ADR_LO_HIST + 8'h10);
    chk("record sensor", 32'h0000_0123, q);
    cy(20);
    chk("latched", 32'h1, 32'(lck));
    wr(ADR_CTRL, 32'h0000_0001);
    cy(3);
    chk("bus clear", 32'h0, 32'(lck));
    state_is(2'b01);
  endtask

  task automatic t_resets;
    wr(ADR_SAFE_PARAM, 32'h0000_0001);
    cy(3);
    chk("safety write locks", 32'h1, 32'(lck));
    press <= 1'b1;
    @(posedge mclk_i);
    press <= 1'b0;
    cy(16);
    chk("button clear", 32'h0, 32'(lck));
    state_is(2'b00);
    wr(ADR_CTRL, 32'h0000_0002);
    cy(3);
    state_is(2'b01);
    lock_now();
    rrst <= 1'b1;
    cy(5);
    rrst <= 1'b0;
    cy(8);
    chk("remote clear", 32'h0, 32'(lck));
    lock_now();
    pwr <= 1'b1;
    cy(5);
    chk("power clears", 32'h0, 32'(lck));
    pwr <= 1'b0;
    wr(ADR_CTRL, 32'h0000_0004);
    lock_now();
    pwr <= 1'b1;
    cy(5);
    chk("lock persists", 32'h1, 32'(lck));
    pwr <= 1'b0;
    wr(ADR_CTRL, 32'h0000_0001);
    cy(3);
  endtask

  task automatic t_alerts;
    wr(ADR_ALERT_ALARM, 32'h0000_0008);
    alert(4'h3);
    chk("alarm masked in", 32'h1, 32'(seen));
    chk("alert no stop", 32'h1, 32'({lck, en}));
    alert(4'h2);
    chk("alarm masked out", 32'h0, 32'(seen));
    alert(4'h3);
    wr(ADR_HIST_SEL, 32'h0000_0000);
    rd(ADR_AL_HIST);
    chk("alert newest", 32'h0000_0013, q);
    wr(ADR_HIST_SEL, 32'h0000_0001);
    rd(ADR_AL_HIST);
    chk("alert second", 32'h0000_0012, q);
    wr(ADR_HIST_SEL, 32'h0000_0002);
    rd(ADR_AL_HIST);
    chk("alert third", 32'h0000_0000, q);
  endtask

  task automatic t_sensor;
    wr(ADR_NONSAFE, 32'h0E00_0100);
    sens(12'h050, 12'h050, 3'b000, 3'b000);
    sens(12'h050, 12'h050, 3'b100, 3'b001);
    sens(12'h050, 12'h050, 3'b101, 3'b000);
    sens(12'hF00, 12'hF00, 3'b100, 3'b010);
    sens(12'h800, 12'h700, 3'b110, 3'b100);
    {req, red, dig} <= 3'b000;
    wr(ADR_HIST_SEL, 32'h0000_0000);
    rd(ADR_AL_HIST);
    chk("sensor alert", 32'h0000_001F, q);
    slk <= 1'b1;
    sens(12'h050, 12'h050, 3'b100, 3'b001);
    chk("sensor lock", 32'h1, 32'(lck));
    slk <= 1'b0;
    {req, red, dig} <= 3'b000;
    wr(ADR_CTRL, 32'h0000_0001);
    cy(3);
  endtask

  task automatic t_counters;
    wr(ADR_CNT_SEL, 32'h0000_0001);
    wr(ADR_CNT_DATA, 32'h000F_FFFF);
    rd(ADR_CNT_DATA);
    chk("clamped write", 32'(CNT_MAX), q);
    wr(ADR_CNT_SEL, 32'h0000_0007);
    wr(ADR_CNT_DATA, 32'h0000_5A5A);
    rd(ADR_CNT_DATA);
    num_checks++;
    if (q === 32'h0000_5A5A) begin
      n_errors++;
      $display("unexpected control count: expected unchanged seen %h", q);
    end
    wr(ADR_CNT_SEL, 32'h0000_0000);
    wr(ADR_CNT_DATA, 32'(CNT_MAX));
    valve <= 1'b0;
    cy(2);
    valve <= 1'b1;
    cy(3);
    rd(ADR_CNT_DATA);
    chk("saturated", 32'(CNT_MAX), q);
  endtask

  task automatic t_flame_loss;
    flame_present <= 1'b0;
    seen = 1'b0;
    repeat (FLC + 40) begin
      @(posedge mclk_i);
      seen = seen | ffail;
    end
    chk("flame failure", 32'h1, 32'(seen));
    chk("flame off", 32'h0, 32'(fon));
    valve <= 1'b0;
    scf <= 1'b1;
    cy(4);
    chk("relay dropped", 32'h0, 32'({relay, en}));
  endtask

  initial begin
    reset_i = 1'b1;
    {cyc, stb, we, rrst, scf, valve, lreq, areq, req, red, dig, press, pwr, slk} = 14'h0000;
    flame_present = 1'b0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    sel = 4'h0;
    {bst, fo, cause} = 24'h00_0000;
    tmr = 16'h0000;
    acode = 4'h0;
    sa = 12'h000;
    sb = 12'h000;
    cy(3);
    reset_i <= 1'b0;
    cy(1);
    t_defaults();
    t_configure();
    t_lockout();
    t_resets();
    t_alerts();
    t_sensor();
    t_counters();
    t_flame_loss();
    print_verdict();
  end
endmodule
